// ---- core/ato_map.vh ----
// Purpose: constants for the accumulator transfer block
// Assumes: 10-bit instruction words, 4-bit data path
// Notes:   offsets are APB byte addresses
`ifndef ATO_MAP_VH
`define ATO_MAP_VH
// opcodes
`define ATO_OP_POINTER_TO_ACC   10'h053
`define ATO_OP_ACC_TO_BREG      10'h00e
`define ATO_OP_ACC_TO_DREG      10'h029
`define ATO_OP_PAIR_TO_EREG     10'h01a
`define ATO_OP_ACC_TO_INTCTL    10'h217
`define ATO_OP_ACC_TO_WAKE_1    10'h213
`define ATO_OP_ACC_TO_WAKE_2    10'h214
`define ATO_OP_ACC_TO_WAKE_3    10'h215
// decoded operation codes
`define ATO_SEL_NONE  4'h0
`define ATO_SEL_PTR   4'h1
`define ATO_SEL_B     4'h2
`define ATO_SEL_D     4'h3
`define ATO_SEL_E     4'h4
`define ATO_SEL_I1    4'h5
`define ATO_SEL_K0    4'h6
`define ATO_SEL_K1    4'h7
`define ATO_SEL_K2    4'h8
// register offsets
`define ATO_ADDR_INSTR  12'h000
`define ATO_ADDR_ACC    12'h004
`define ATO_ADDR_PTR    12'h008
`define ATO_ADDR_BREG   12'h00c
`define ATO_ADDR_DREG   12'h010
`define ATO_ADDR_EREG   12'h014
`define ATO_ADDR_INTCTL 12'h018
`define ATO_ADDR_WAKE1  12'h01c
`define ATO_ADDR_WAKE2  12'h020
`define ATO_ADDR_WAKE3  12'h024
`define ATO_ADDR_STATUS 12'h028
`define ATO_ADDR_CARRY  12'h02c
// reset values
`define ATO_RST_NIB   4'h0
`define ATO_RST_DREG  3'h0
`define ATO_RST_EREG  8'h00
`endif

// ---- core/ato_decode.v ----
// Purpose: decodes one instruction word into an operation select
// Assumes: word is valid in the cycle it is presented
// Notes:   unknown words decode to none
`timescale 1ns/100ps
`default_nettype none
`include "ato_map.vh"
module ato_decode (
    // instruction in
    input  wire [9:0] instr,
    // decoded select
    output reg  [3:0] sel
);
    // opcode lookup
    always @* begin
        case (instr)
            `ATO_OP_POINTER_TO_ACC: sel = `ATO_SEL_PTR;
            `ATO_OP_ACC_TO_BREG:    sel = `ATO_SEL_B;
            `ATO_OP_ACC_TO_DREG:    sel = `ATO_SEL_D;
            `ATO_OP_PAIR_TO_EREG:   sel = `ATO_SEL_E;
            `ATO_OP_ACC_TO_INTCTL:  sel = `ATO_SEL_I1;
            `ATO_OP_ACC_TO_WAKE_1:  sel = `ATO_SEL_K0;
            `ATO_OP_ACC_TO_WAKE_2:  sel = `ATO_SEL_K1;
            `ATO_OP_ACC_TO_WAKE_3:  sel = `ATO_SEL_K2;
            default:                sel = `ATO_SEL_NONE;
        endcase
    end
endmodule // ato_decode
`default_nettype wire

// ---- core/ato_core.v ----
// Purpose: executes the accumulator transfer instruction group
// Assumes: software loads operands and issues words over APB
// Notes:   one write to the instruction register runs one instruction
//          a read right behind an op returns the forwarded result
//          software writes to acc or B while an op lands are dropped
//          unmapped addresses answer with pslverr and read as zero
// Behaviour
// - the pointer opcode loads acc bits 1..0 from the pointer, clears bits 3..2, in one cycle.
// - the acc-to-B opcode copies all four acc bits into B in one cycle, carry kept, no skip.
// - the acc-to-D opcode copies acc bits 2..0 into D, ignores bit 3, carry kept.
// - the pair opcode writes B into E bits 7..4 and acc into E bits 3..0 in one cycle.
// - the interrupt opcode writes the acc into the interrupt control register in one cycle.
// - the first wakeup opcode writes the acc into the first wakeup register, carry kept.
// - the second wakeup opcode writes the acc into the second wakeup register in one cycle.
// - the third wakeup opcode writes the acc into the third wakeup register in one cycle.
//
// Implementation choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "ato_map.vh"
module ato_core (
    // clock and reset
    input  wire        clock,
    input  wire        arst_n,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // register contents
    output reg  [3:0]  acc_reg,
    output reg  [3:0]  breg_reg,
    output reg  [2:0]  dreg_reg,
    output reg  [7:0]  ereg_reg,
    output reg  [3:0]  intctl_first_reg,
    output reg  [3:0]  wake_ctl_first_reg,
    output reg  [3:0]  wake_ctl_second_reg,
    output reg  [3:0]  wake_ctl_third_reg,
    output reg         carry_flag_reg,
    output reg         exec_pulse_reg
);
    // operand and control state
    reg  [1:0]  ptr_reg;
    reg  [9:0]  instr_reg;
    reg         go_reg;
    reg  [3:0]  last_sel_reg;
    reg  [31:0] rdata_next;
    reg         known_next;
    wire [3:0]  sel;
    wire        wr_acc;
    // destination values once the op now executing lands
    reg  [3:0]  acc_next;
    reg  [3:0]  breg_next;
    reg  [2:0]  dreg_next;
    reg  [7:0]  ereg_next;
    reg  [3:0]  intctl_first_next;
    reg  [3:0]  wake_ctl_first_next;
    reg  [3:0]  wake_ctl_second_next;
    reg  [3:0]  wake_ctl_third_next;

    // decodes the held word
    ato_decode ato_decode_inst (
        .instr (instr_reg),
        .sel   (sel)
    );

    // access phase write strobe
    assign wr_acc = psel & penable & pwrite;

    // checks whether an address maps to a register
    function is_mapped;
        input [11:0] a;
        begin
            is_mapped = (a == `ATO_ADDR_INSTR) || (a == `ATO_ADDR_ACC) ||
                        (a == `ATO_ADDR_PTR) || (a == `ATO_ADDR_BREG) ||
                        (a == `ATO_ADDR_DREG) || (a == `ATO_ADDR_EREG) ||
                        (a == `ATO_ADDR_INTCTL) ||
                        (a == `ATO_ADDR_WAKE1) || (a == `ATO_ADDR_WAKE2) ||
                        (a == `ATO_ADDR_WAKE3) ||
                        (a == `ATO_ADDR_STATUS) || (a == `ATO_ADDR_CARRY);
        end
    endfunction

    // widens a nibble to a bus word
    function [31:0] zext4;
        input [3:0] v;
        begin
            zext4 = {28'h0000000, v};
        end
    endfunction

    // forwards the result of the op now executing, so that a read issued
    // right behind an instruction already sees the new contents
    always @* begin
        acc_next             = acc_reg;
        breg_next            = breg_reg;
        dreg_next            = dreg_reg;
        ereg_next            = ereg_reg;
        intctl_first_next    = intctl_first_reg;
        wake_ctl_first_next  = wake_ctl_first_reg;
        wake_ctl_second_next = wake_ctl_second_reg;
        wake_ctl_third_next  = wake_ctl_third_reg;
        if (go_reg) begin
            // one cycle; carry never touched, no skip
            case (sel)
                `ATO_SEL_PTR: acc_next = {2'b00, ptr_reg};
                `ATO_SEL_B:   breg_next = acc_reg;
                `ATO_SEL_D:   dreg_next = acc_reg[2:0];
                `ATO_SEL_E:   ereg_next = {breg_reg, acc_reg};
                `ATO_SEL_I1:  intctl_first_next = acc_reg;
                `ATO_SEL_K0:  wake_ctl_first_next = acc_reg;
                `ATO_SEL_K1:  wake_ctl_second_next = acc_reg;
                `ATO_SEL_K2:  wake_ctl_third_next = acc_reg;
                default:      acc_next = acc_reg;
            endcase
        end
    end

    // read mux; destinations read through their forwarded values
    always @* begin
        rdata_next = 32'h0000_0000;
        known_next = is_mapped(paddr);
        if (paddr == `ATO_ADDR_INSTR) begin
            rdata_next = {22'h000000, instr_reg};
        end else if (paddr == `ATO_ADDR_ACC) begin
            rdata_next = zext4(acc_next);
        end else if (paddr == `ATO_ADDR_PTR) begin
            rdata_next = {30'h00000000, ptr_reg};
        end else if (paddr == `ATO_ADDR_BREG) begin
            rdata_next = zext4(breg_next);
        end else if (paddr == `ATO_ADDR_DREG) begin
            rdata_next = {29'h00000000, dreg_next};
        end else if (paddr == `ATO_ADDR_EREG) begin
            rdata_next = {24'h000000, ereg_next};
        end else if (paddr == `ATO_ADDR_INTCTL) begin
            rdata_next = zext4(intctl_first_next);
        end else if (paddr == `ATO_ADDR_WAKE1) begin
            rdata_next = zext4(wake_ctl_first_next);
        end else if (paddr == `ATO_ADDR_WAKE2) begin
            rdata_next = zext4(wake_ctl_second_next);
        end else if (paddr == `ATO_ADDR_WAKE3) begin
            rdata_next = zext4(wake_ctl_third_next);
        end else if (paddr == `ATO_ADDR_STATUS) begin
            rdata_next = {27'h0000000, go_reg, last_sel_reg};
        end else if (paddr == `ATO_ADDR_CARRY) begin
            rdata_next = {31'h00000000, carry_flag_reg};
        end else begin
            rdata_next = 32'h0000_0000; // unmapped reads as zero
        end
    end

    // apb answer: ready in the first access cycle, error when unmapped
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~known_next;
            prdata  <= (psel & ~penable & ~pwrite) ? rdata_next : 32'h0;
        end
    end

    // register writes and single-cycle execution
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            acc_reg             <= `ATO_RST_NIB;
            ptr_reg             <= 2'h0;
            breg_reg            <= `ATO_RST_NIB;
            dreg_reg            <= `ATO_RST_DREG;
            ereg_reg            <= `ATO_RST_EREG;
            intctl_first_reg    <= `ATO_RST_NIB;
            wake_ctl_first_reg  <= `ATO_RST_NIB;
            wake_ctl_second_reg <= `ATO_RST_NIB;
            wake_ctl_third_reg  <= `ATO_RST_NIB;
            carry_flag_reg      <= 1'b0;
            instr_reg           <= 10'h000;
            go_reg              <= 1'b0;
            last_sel_reg        <= `ATO_SEL_NONE;
            exec_pulse_reg      <= 1'b0;
        end else begin
            // pulse rises as an op lands, one cycle after the word is taken
            exec_pulse_reg <= go_reg;
            go_reg         <= 1'b0;
            if (go_reg) begin
                // the destination takes its forwarded value
                last_sel_reg        <= sel;
                acc_reg             <= acc_next;
                breg_reg            <= breg_next;
                dreg_reg            <= dreg_next;
                ereg_reg            <= ereg_next;
                intctl_first_reg    <= intctl_first_next;
                wake_ctl_first_reg  <= wake_ctl_first_next;
                wake_ctl_second_reg <= wake_ctl_second_next;
                wake_ctl_third_reg  <= wake_ctl_third_next;
            end else if (wr_acc && pready) begin
                // software loads; ignored while executing
                if (paddr == `ATO_ADDR_INSTR) begin
                    instr_reg <= pwdata[9:0];
                    go_reg    <= 1'b1;
                end else if (paddr == `ATO_ADDR_ACC) begin
                    acc_reg <= pwdata[3:0];
                end else if (paddr == `ATO_ADDR_PTR) begin
                    ptr_reg <= pwdata[1:0];
                end else if (paddr == `ATO_ADDR_BREG) begin
                    breg_reg <= pwdata[3:0];
                end else if (paddr == `ATO_ADDR_CARRY) begin
                    carry_flag_reg <= pwdata[0];
                end
            end
        end
    end
endmodule // ato_core
`default_nettype wire

// ---- verif/ato_checker.sv ----
// Purpose: checks results of the transfer ops and timing of the acc-to-B op
// Assumes: no software write to acc or B right behind an op
// Notes:   bound into ato_core, operands caught when a word is taken
`timescale 1ns/100ps
`default_nettype none
`include "ato_map.vh"
module ato_checker (
    // clock, reset and apb
    input wire logic        clock,
    input wire logic        arst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic        pready,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    // register contents
    input wire logic [3:0]  acc_reg,
    input wire logic [3:0]  breg_reg,
    input wire logic [2:0]  dreg_reg,
    input wire logic [7:0]  ereg_reg,
    input wire logic [3:0]  intctl_first_reg,
    input wire logic [3:0]  wake_ctl_first_reg,
    input wire logic [3:0]  wake_ctl_second_reg,
    input wire logic [3:0]  wake_ctl_third_reg,
    input wire logic        carry_flag_reg,
    input wire logic        exec_pulse_reg
);
    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);
    // completed write and instruction word
    wire       go = psel && penable && pready && pwrite;
    wire       ex = exec_pulse_reg;
    wire       run = go && paddr == `ATO_ADDR_INSTR;
    reg  [9:0] op_reg;
    wire       k0_op = op_reg == `ATO_OP_ACC_TO_WAKE_1;
    wire       k1_op = op_reg == `ATO_OP_ACC_TO_WAKE_2;
    reg  [3:0] sa_reg;
    reg  [3:0] sb_reg;
    // operands as seen when the word is taken
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n)
            {op_reg, sa_reg, sb_reg} <= 18'h0;
        else if (run)
            {op_reg, sa_reg, sb_reg} <= {pwdata[9:0], acc_reg, breg_reg};
    end
    a_ptr_clear: assert property (ex && op_reg == `ATO_OP_POINTER_TO_ACC
        |-> acc_reg[3:2] == 2'b00) else $error("acc high bits kept");
    a_b_copy: assert property (ex && op_reg == `ATO_OP_ACC_TO_BREG
        |-> breg_reg == sa_reg) else $error("B copy wrong");
    a_d_copy: assert property (ex && op_reg == `ATO_OP_ACC_TO_DREG
        |-> dreg_reg == sa_reg[2:0]) else $error("D copy wrong");
    a_e_pair: assert property (ex && op_reg == `ATO_OP_PAIR_TO_EREG
        |-> ereg_reg == {sb_reg, sa_reg}) else $error("E pair wrong");
    a_intctl_copy: assert property (ex && op_reg == `ATO_OP_ACC_TO_INTCTL
        |-> intctl_first_reg == sa_reg) else $error("intctl copy wrong");
    a_wake_copy: assert property (ex && op_reg == `ATO_OP_ACC_TO_WAKE_3
        |-> wake_ctl_third_reg == sa_reg) else $error("wake copy wrong");
    a_wake_first: assert property (ex && k0_op
        |-> wake_ctl_first_reg == sa_reg) else $error("wake first wrong");
    a_wake_second: assert property (ex && k1_op
        |-> wake_ctl_second_reg == sa_reg) else $error("wake second wrong");
    a_exec_time: assert property (run && pwdata[9:0] == 10'h00e
        |-> ##[2:3] ex) else $error("no execution pulse");
    a_carry_kept: assert property (!(go && paddr == `ATO_ADDR_CARRY)
        |=> $stable(carry_flag_reg)) else $error("carry changed by op");
endmodule // ato_checker
bind ato_core ato_checker ato_checker_inst (.*);
`default_nettype wire

// ---- verif/testbench.sv ----
// Purpose: runs each transfer op over apb and checks the results
// Assumes: zero wait apb slave, one op per transfer
// Notes:   back to back ops show the next op sees new contents
`timescale 1ns/100ps
`default_nettype none
`include "ato_map.vh"
`define CHK(g, x) begin checked++; if ((g) !== (x)) begin n_mismatch++; \
    $display("MISMATCH %0t got %h exp %h", $time, g, x); end end
module testbench;
    logic        clock = 1'b0, arst_n = 1'b0, err, pwrite = 1'b0;
    logic        psel = 1'b0, penable = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, rd;
    wire  [31:0] prdata;
    wire         pready, pslverr, cy, ex;
    wire  [3:0]  acc, b, i1, k0, k1, k2;
    wire  [2:0]  d;
    wire  [7:0]  e;
    int          n_mismatch = 0, checked = 0, cyc = 0, i;
    logic [9:0]  ops [4] = '{`ATO_OP_ACC_TO_INTCTL, `ATO_OP_ACC_TO_WAKE_1,
                             `ATO_OP_ACC_TO_WAKE_2, `ATO_OP_ACC_TO_WAKE_3};
    logic [11:0] ads [4] = '{`ATO_ADDR_INTCTL, `ATO_ADDR_WAKE1,
                             `ATO_ADDR_WAKE2, `ATO_ADDR_WAKE3};
    ato_core ato_core_inst (.clock(clock), .arst_n(arst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .acc_reg(acc),
        .breg_reg(b), .dreg_reg(d), .ereg_reg(e), .intctl_first_reg(i1),
        .wake_ctl_first_reg(k0), .wake_ctl_second_reg(k1),
        .wake_ctl_third_reg(k2), .carry_flag_reg(cy), .exec_pulse_reg(ex));
    // clock and cycle ceiling
    always #2 clock = ~clock;
    always @(posedge clock) begin
        cyc++;
        if (cyc == 1000) begin
            n_mismatch++;
            print_verdict();
        end
    end
    task print_verdict();
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // one apb transfer, left up so a setup may follow at once
    task apb(input logic w, input logic [11:0] a, input logic [31:0] v);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= v;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
    endtask
    // reset, then each op with its expected result
    initial begin
        repeat (6) @(posedge clock);
        arst_n <= 1'b1;
        `CHK({acc, b, d, e, i1, k0, k1, k2, cy, ex}, 37'h0)
        @(posedge clock);
        apb(1'b1, `ATO_ADDR_CARRY, 32'h1);
        apb(1'b1, `ATO_ADDR_ACC, 32'hf);
        apb(1'b1, `ATO_ADDR_PTR, 32'h2);
        apb(1'b1, `ATO_ADDR_INSTR, {22'h0, `ATO_OP_POINTER_TO_ACC});
        apb(1'b0, `ATO_ADDR_ACC, 32'h0);
        `CHK(rd, 32'h2)
        apb(1'b1, `ATO_ADDR_ACC, 32'hd);
        apb(1'b1, `ATO_ADDR_INSTR, {22'h0, `ATO_OP_ACC_TO_BREG});
        apb(1'b1, `ATO_ADDR_INSTR, {22'h0, `ATO_OP_PAIR_TO_EREG});
        apb(1'b1, `ATO_ADDR_INSTR, {22'h0, `ATO_OP_ACC_TO_DREG});
        apb(1'b0, `ATO_ADDR_EREG, 32'h0);
        `CHK(rd, 32'hdd)
        `CHK({b, d}, 7'h6d)
        for (i = 0; i < 4; i++) begin
            apb(1'b1, `ATO_ADDR_ACC, 32'h5 + 32'h3 * i);
            apb(1'b1, `ATO_ADDR_INSTR, {22'h0, ops[i]});
            apb(1'b0, ads[i], 32'h0);
            `CHK(rd, 32'h5 + 32'h3 * i)
        end
        `CHK({i1, k0, k1, k2}, 16'h58be)
        apb(1'b0, `ATO_ADDR_STATUS, 32'h0);
        `CHK(rd, 32'h8)
        apb(1'b0, `ATO_ADDR_CARRY, 32'h0);
        `CHK(rd, 32'h1)
        apb(1'b0, 12'h030, 32'h0);
        `CHK({err, rd}, 33'h100000000)
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
        print_verdict();
    end
endmodule // testbench
`default_nettype wire
